// *** rtl/pswc_pkg.sv ***
package pswc_pkg;

    // special function register addresses
    localparam logic [15:0] RESET_CTRL_ADDR = 16'h0740;
    localparam logic [15:0] PMD1_ADDR       = 16'h0770;
    localparam logic [15:0] PMD2_ADDR       = 16'h0772;

    // configuration word table addresses
    localparam logic [23:0] OSC_CFG_ADDR    = 24'hf80000;
    localparam logic [23:0] WDT_CFG_ADDR    = 24'hf80002;
    localparam logic [23:0] BORPOR_CFG_ADDR = 24'hf80004;
    localparam logic [23:0] SEG_CFG_ADDR    = 24'hf8000a;
    localparam logic [7:0]  CFG_UPPER_FILL  = 8'h00;

    // reset_control_status bit positions
    localparam int RC_POR      = 0;
    localparam int RC_BOR      = 1;
    localparam int RC_IDLE     = 2;
    localparam int RC_SLEEP    = 3;
    localparam int RC_WATCHDOG_TIMEOUT_FLAG     = 4;
    localparam int RC_WATCHDOG_SOFT_ENABLE   = 5;
    localparam int RC_EXTR     = 7;
    localparam int RC_LVL_LSB  = 8;
    localparam int RC_LOW_VOLTAGE_DETECT_ENABLE    = 12;
    localparam int RC_REFERENCE_STABLE_FLAG     = 13;
    localparam logic [15:0] RC_RW_MASK   = 16'hdfff;
    localparam logic [15:0] RC_POR_VALUE = 16'h0003;
    localparam logic [15:0] PMD_RESET    = 16'h0000;

    // configuration fields
    localparam int WDT_FUSE_BIT = 15;
    localparam int FOS_LSB      = 8;

    // oscillator source encodings of current_oscillator_field
    localparam logic [1:0] OSC_SRC_LOW_POWER_RC = 2'h0;
    localparam logic [1:0] OSC_SRC_FAST_RC      = 2'h1;
    localparam logic [1:0] OSC_SRC_LP_CRYSTAL   = 2'h2;
    localparam logic [1:0] OSC_SRC_PRIMARY      = 2'h3;

    // timing
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          POR_DELAY_US    = 10;
    localparam logic [15:0] POR_DELAY_CYC   =
        16'((POR_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] OST_CYCLES      = 16'd1024;
    localparam logic [7:0]  WDT_TICK_CYCLES = 8'd100;
    localparam logic [7:0]  WDT_CNT_MAX     = 8'hff;

    typedef enum logic [2:0] {
        ST_RUN      = 3'b000,
        ST_SLEEP    = 3'b001,
        ST_WAKE_POR = 3'b011,
        ST_WAKE_OSC = 3'b010,
        ST_WAKE_CHK = 3'b110,
        ST_IDLE     = 3'b100
    } pswc_state_e;

endpackage

// *** rtl/pswc_top.sv ***
`timescale 1ns/1ps
module pswc_top #(
    parameter logic [15:0] PWRT_CYCLES = 16'd4000
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // nonvolatile configuration cells
    input  wire logic [15:0] cfg_osc_in,
    input  wire logic [15:0] cfg_wdt_in,
    input  wire logic [15:0] cfg_borpor_in,
    input  wire logic [15:0] cfg_seg_in,
    // special function register port
    input  wire logic [15:0] sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [15:0] sfr_wdata,
    output logic      [15:0] sfr_rdata,
    // table read port
    input  wire logic [23:0] tbl_addr,
    input  wire logic        tbl_rd,
    output logic      [23:0] tbl_rdata,
    // core instructions and interrupt
    input  wire logic        instr_watchdog_clear_instr,
    input  wire logic        instr_power_save_instr,
    input  wire logic        power_save_instr_sleep,
    input  wire logic        irq_wake,
    // reset sources
    input  wire logic        bor_rst,
    input  wire logic        mclr_rst,
    // oscillator and analog status
    input  wire logic [1:0]  cur_osc_field,
    input  wire logic        prim_is_crystal,
    input  wire logic        pll_en,
    input  wire logic        pll_lock,
    input  wire logic        lp_kept_on,
    input  wire logic        osc_running,
    input  wire logic        failsafe_en,
    input  wire logic        ref_stable,
    // clock control
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic             sys_osc_en,
    output logic             low_power_rc_oscillator_en,
    output logic      [1:0]  osc_restart_sel,
    output logic             frc_force_en,
    output logic             clk_fail_trap,
    // core control
    output logic             irq_service,
    output logic             dev_reset,
    // low-voltage detect and peripheral gating
    output logic             lvd_en,
    output logic      [3:0]  lvd_level,
    output logic      [31:0] periph_off
);

    localparam logic [15:0] OSC_WAIT = PWRT_CYCLES + pswc_pkg::OST_CYCLES - 16'd1;

    pswc_pkg::pswc_state_e state_reg;
    pswc_pkg::pswc_state_e state_next;
    logic [15:0] cfg_osc_reg;
    logic [15:0] cfg_wdt_reg;
    logic [15:0] cfg_borpor_reg;
    logic [15:0] cfg_seg_reg;
    logic [15:0] reset_control_status_reg;
    logic [15:0] reset_control_status_next;
    logic [15:0] reset_control_status_set;
    logic [15:0] pmd1_reg;
    logic [15:0] pmd2_reg;
    logic [7:0]  tick_cnt_reg;
    logic [7:0]  wdt_cnt_reg;
    logic [15:0] delay_cnt_reg;
    logic        wake_irq_reg;
    logic        wdt_on;
    logic        wdt_tick;
    logic        wdt_ovf;
    logic        reset_evt;
    logic        any_wake;
    logic        irq_only;
    logic        slow_path;
    logic        svc_now;

    // configuration cells are captured while reset is held
    always_ff @(posedge clock) begin
        if (srst) begin
            cfg_osc_reg    <= cfg_osc_in;
            cfg_wdt_reg    <= cfg_wdt_in;
            cfg_borpor_reg <= cfg_borpor_in;
            cfg_seg_reg    <= cfg_seg_in;
        end
    end

    // watchdog: fuse forces it on, otherwise software bit
    assign wdt_on    = cfg_wdt_reg[pswc_pkg::WDT_FUSE_BIT]
                     | reset_control_status_reg[pswc_pkg::RC_WATCHDOG_SOFT_ENABLE];
    assign wdt_tick  = wdt_on && (tick_cnt_reg == pswc_pkg::WDT_TICK_CYCLES - 8'd1);
    assign wdt_ovf   = wdt_tick && (wdt_cnt_reg == pswc_pkg::WDT_CNT_MAX);
    assign reset_evt = bor_rst | mclr_rst;
    assign any_wake  = reset_evt | wdt_ovf | irq_wake;
    assign irq_only  = irq_wake && !reset_evt && !wdt_ovf;

    // prescale divider standing in for the low-power RC time base
    always_ff @(posedge clock) begin
        if (srst || instr_watchdog_clear_instr || !wdt_on) begin
            tick_cnt_reg <= 8'h00;
        end else if (wdt_tick) begin
            tick_cnt_reg <= 8'h00;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 8'd1;
        end
    end

    // clear wins over a tick in the same cycle
    always_ff @(posedge clock) begin
        if (srst || instr_watchdog_clear_instr || !wdt_on) begin
            wdt_cnt_reg <= 8'h00;
        end else if (wdt_tick) begin
            wdt_cnt_reg <= wdt_cnt_reg + 8'd1;
        end
    end

    // primary crystal or PLL needs the long path; kept LP crystal does not
    always_comb begin
        slow_path = 1'b0;
        if (cur_osc_field == pswc_pkg::OSC_SRC_PRIMARY) begin
            slow_path = prim_is_crystal | pll_en;
        end else if (cur_osc_field == pswc_pkg::OSC_SRC_LP_CRYSTAL) begin
            slow_path = !lp_kept_on;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            pswc_pkg::ST_RUN: begin
                if (instr_power_save_instr && !reset_evt && !wdt_ovf) begin
                    state_next = power_save_instr_sleep ? pswc_pkg::ST_SLEEP : pswc_pkg::ST_IDLE;
                end
            end
            pswc_pkg::ST_SLEEP: begin
                if (any_wake) begin
                    state_next = pswc_pkg::ST_WAKE_POR;
                end
            end
            pswc_pkg::ST_IDLE: begin
                if (any_wake) begin
                    state_next = pswc_pkg::ST_RUN;
                end
            end
            pswc_pkg::ST_WAKE_POR: begin
                if (delay_cnt_reg == 16'h0000) begin
                    state_next = slow_path ? pswc_pkg::ST_WAKE_OSC : pswc_pkg::ST_RUN;
                end
            end
            pswc_pkg::ST_WAKE_OSC: begin
                if (delay_cnt_reg == 16'h0000 && (!pll_en || pll_lock)) begin
                    state_next = pswc_pkg::ST_WAKE_CHK;
                end
            end
            pswc_pkg::ST_WAKE_CHK: begin
                if (osc_running || failsafe_en) begin
                    state_next = pswc_pkg::ST_RUN;
                end
            end
            default: begin
                state_next = pswc_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= pswc_pkg::ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // one down-counter serves both delay phases
    always_ff @(posedge clock) begin
        if (srst) begin
            delay_cnt_reg <= 16'h0000;
        end else if (state_reg == pswc_pkg::ST_SLEEP && state_next == pswc_pkg::ST_WAKE_POR) begin
            delay_cnt_reg <= pswc_pkg::POR_DELAY_CYC - 16'd1;
        end else if (state_reg == pswc_pkg::ST_WAKE_POR
                     && state_next == pswc_pkg::ST_WAKE_OSC) begin
            delay_cnt_reg <= OSC_WAIT;
        end else if (delay_cnt_reg != 16'h0000) begin
            delay_cnt_reg <= delay_cnt_reg - 16'd1;
        end
    end

    // a reset during the wake overrides a pending interrupt; a time-out does not
    always_ff @(posedge clock) begin
        if (srst) begin
            wake_irq_reg <= 1'b0;
        end else if (state_reg == pswc_pkg::ST_SLEEP && any_wake) begin
            wake_irq_reg <= irq_only;
        end else if (state_reg != pswc_pkg::ST_SLEEP && reset_evt) begin
            wake_irq_reg <= 1'b0;
        end
    end

    assign svc_now = (state_reg == pswc_pkg::ST_IDLE && irq_only)
                   || (state_reg != pswc_pkg::ST_RUN && state_reg != pswc_pkg::ST_IDLE
                       && state_reg != pswc_pkg::ST_SLEEP
                       && state_next == pswc_pkg::ST_RUN && wake_irq_reg && !reset_evt);

    always_ff @(posedge clock) begin
        if (srst) begin
            irq_service <= 1'b0;
            dev_reset   <= 1'b0;
        end else begin
            irq_service <= svc_now;
            dev_reset   <= wdt_ovf && state_reg != pswc_pkg::ST_SLEEP
                           && state_reg != pswc_pkg::ST_IDLE;
        end
    end

    // clock gates follow the state they will be in; the low-power RC enable follows wdt_on or failsafe_en
    always_ff @(posedge clock) begin
        if (srst) begin
            cpu_clk_en    <= 1'b1;
            periph_clk_en <= 1'b1;
            sys_osc_en    <= 1'b1;
            low_power_rc_oscillator_en       <= 1'b0;
        end else begin
            cpu_clk_en    <= state_next == pswc_pkg::ST_RUN;
            periph_clk_en <= state_next == pswc_pkg::ST_RUN
                             || state_next == pswc_pkg::ST_IDLE;
            sys_osc_en    <= state_next != pswc_pkg::ST_SLEEP;
            low_power_rc_oscillator_en       <= wdt_on | failsafe_en;
        end
    end

    // power-on takes the fuse source; Sleep remembers the running one
    always_ff @(posedge clock) begin
        if (srst) begin
            osc_restart_sel <= cfg_osc_in[pswc_pkg::FOS_LSB +: 2];
        end else if (state_reg == pswc_pkg::ST_RUN && state_next == pswc_pkg::ST_SLEEP) begin
            osc_restart_sel <= cur_osc_field;
        end
    end

    // fast RC stays forced until the next reset
    always_ff @(posedge clock) begin
        if (srst) begin
            clk_fail_trap <= 1'b0;
            frc_force_en  <= 1'b0;
        end else begin
            clk_fail_trap <= state_reg == pswc_pkg::ST_WAKE_CHK && !osc_running
                             && failsafe_en;
            if (state_reg == pswc_pkg::ST_WAKE_CHK && !osc_running && failsafe_en) begin
                frc_force_en <= 1'b1;
            end
        end
    end

    // status bits set by hardware; set beats a software clear
    always_comb begin
        reset_control_status_set = 16'h0000;
        if (wdt_ovf) begin
            reset_control_status_set[pswc_pkg::RC_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
        end
        if (state_reg == pswc_pkg::ST_SLEEP && any_wake) begin
            reset_control_status_set[pswc_pkg::RC_SLEEP] = 1'b1;
        end
        if (state_reg == pswc_pkg::ST_IDLE && any_wake) begin
            reset_control_status_set[pswc_pkg::RC_IDLE] = 1'b1;
        end
        if (mclr_rst) begin
            reset_control_status_set[pswc_pkg::RC_EXTR] = 1'b1;
        end
        if (bor_rst) begin
            reset_control_status_set[pswc_pkg::RC_BOR] = 1'b1;
        end
    end

    always_comb begin
        reset_control_status_next = reset_control_status_reg;
        if (sfr_wr && sfr_addr == pswc_pkg::RESET_CTRL_ADDR) begin
            reset_control_status_next = (sfr_wdata & pswc_pkg::RC_RW_MASK) | (reset_control_status_reg & ~pswc_pkg::RC_RW_MASK);
        end
        reset_control_status_next = reset_control_status_next | reset_control_status_set;
        reset_control_status_next[pswc_pkg::RC_REFERENCE_STABLE_FLAG] = ref_stable;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            reset_control_status_reg <= pswc_pkg::RC_POR_VALUE;
        end else begin
            reset_control_status_reg <= reset_control_status_next;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            lvd_en    <= 1'b0;
            lvd_level <= 4'h0;
        end else begin
            lvd_en    <= reset_control_status_reg[pswc_pkg::RC_LOW_VOLTAGE_DETECT_ENABLE];
            lvd_level <= reset_control_status_reg[pswc_pkg::RC_LVL_LSB +: 4];
        end
    end

    // peripheral disable: register, then gate one cycle on
    always_ff @(posedge clock) begin
        if (srst) begin
            pmd1_reg   <= pswc_pkg::PMD_RESET;
            pmd2_reg   <= pswc_pkg::PMD_RESET;
            periph_off <= {pswc_pkg::PMD_RESET, pswc_pkg::PMD_RESET};
        end else begin
            if (sfr_wr && sfr_addr == pswc_pkg::PMD1_ADDR) begin
                pmd1_reg <= sfr_wdata;
            end
            if (sfr_wr && sfr_addr == pswc_pkg::PMD2_ADDR) begin
                pmd2_reg <= sfr_wdata;
            end
            periph_off <= {pmd2_reg, pmd1_reg};
        end
    end

    // read data appears the cycle after the strobe and then holds
    always_ff @(posedge clock) begin
        if (srst) begin
            sfr_rdata <= 16'h0000;
        end else if (sfr_rd) begin
            case (sfr_addr)
                pswc_pkg::RESET_CTRL_ADDR: sfr_rdata <= reset_control_status_reg;
                pswc_pkg::PMD1_ADDR:       sfr_rdata <= pmd1_reg;
                pswc_pkg::PMD2_ADDR:       sfr_rdata <= pmd2_reg;
                default:                   sfr_rdata <= 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            tbl_rdata <= 24'h000000;
        end else if (tbl_rd) begin
            case (tbl_addr)
                pswc_pkg::OSC_CFG_ADDR:    tbl_rdata <= {pswc_pkg::CFG_UPPER_FILL, cfg_osc_reg};
                pswc_pkg::WDT_CFG_ADDR:    tbl_rdata <= {pswc_pkg::CFG_UPPER_FILL, cfg_wdt_reg};
                pswc_pkg::BORPOR_CFG_ADDR: tbl_rdata <= {pswc_pkg::CFG_UPPER_FILL, cfg_borpor_reg};
                pswc_pkg::SEG_CFG_ADDR:    tbl_rdata <= {pswc_pkg::CFG_UPPER_FILL, cfg_seg_reg};
                default:                   tbl_rdata <= 24'h000000;
            endcase
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    sequence sleep_wdt_only_s;
        state_reg == pswc_pkg::ST_SLEEP && wdt_ovf && !reset_evt;
    endsequence

    sequence idle_irq_only_s;
        state_reg == pswc_pkg::ST_IDLE && irq_only;
    endsequence

    wdt_reset_a: assert property (
        wdt_ovf && state_reg == pswc_pkg::ST_RUN |=> dev_reset)
        else $error("watchdog overflow in run gave no reset");

    wdt_clear_a: assert property (
        instr_watchdog_clear_instr |=> wdt_cnt_reg == 8'h00 && tick_cnt_reg == 8'h00)
        else $error("watchdog clear did not zero the counter");

    wdt_fuse_a: assert property (
        cfg_wdt_reg[pswc_pkg::WDT_FUSE_BIT] && wdt_tick && !instr_watchdog_clear_instr
        |=> wdt_cnt_reg == $past(wdt_cnt_reg) + 8'd1)
        else $error("fused watchdog did not count");

    sleep_wdt_a: assert property (
        sleep_wdt_only_s |=> state_reg == pswc_pkg::ST_WAKE_POR
        && reset_control_status_reg[pswc_pkg::RC_SLEEP] && reset_control_status_reg[pswc_pkg::RC_WATCHDOG_TIMEOUT_FLAG])
        else $error("sleep time-out did not wake with both flags");

    sleep_clocks_a: assert property (
        state_reg == pswc_pkg::ST_SLEEP |-> !cpu_clk_en && !periph_clk_en && !sys_osc_en)
        else $error("clocks running in sleep");

    por_delay_a: assert property (
        state_reg == pswc_pkg::ST_SLEEP ##1 state_reg == pswc_pkg::ST_WAKE_POR
        |-> (state_reg == pswc_pkg::ST_WAKE_POR && !cpu_clk_en)[*8])
        else $error("power-on delay cut short");

    idle_wake_a: assert property (
        idle_irq_only_s |=> state_reg == pswc_pkg::ST_RUN && cpu_clk_en && irq_service
        && reset_control_status_reg[pswc_pkg::RC_IDLE])
        else $error("idle wake not immediate");

    idle_clocks_a: assert property (
        state_reg == pswc_pkg::ST_IDLE |-> !cpu_clk_en && periph_clk_en && sys_osc_en)
        else $error("idle clock gating wrong");

    pmd_gate_a: assert property (
        sfr_wr && sfr_addr == pswc_pkg::PMD1_ADDR
        |=> ##1 periph_off[15:0] == $past(sfr_wdata, 2))
        else $error("peripheral disable not applied one cycle after");

    fail_trap_a: assert property (
        state_reg == pswc_pkg::ST_WAKE_CHK && !osc_running && failsafe_en
        |=> clk_fail_trap && frc_force_en && state_reg == pswc_pkg::ST_RUN)
        else $error("clock failure trap missing");

endmodule // pswc_top

// *** dv/pswc_core_model.sv ***
`timescale 1ns/1ps
module pswc_core_model (
    // clock
    input  wire logic clock,
    // instruction strobes
    output logic      instr_watchdog_clear_instr,
    output logic      instr_power_save_instr,
    output logic      power_save_instr_sleep
);
    initial begin
        instr_watchdog_clear_instr = 1'b0;
        instr_power_save_instr = 1'b0;
        power_save_instr_sleep = 1'b0;
    end
    // operand inverted after the strobe so a stale value is never trusted
    task automatic exec_power_save_instr(input logic sleep);
        instr_power_save_instr = 1'b1;
        power_save_instr_sleep = sleep;
        @(posedge clock);
        #1;
        instr_power_save_instr = 1'b0;
        power_save_instr_sleep = ~sleep;
    endtask
    task automatic exec_watchdog_clear_instr();
        instr_watchdog_clear_instr = 1'b1;
        @(posedge clock);
        #1;
        instr_watchdog_clear_instr = 1'b0;
    endtask
endmodule // pswc_core_model

// *** dv/pswc_top_test.sv ***
`timescale 1ns/1ps
module pswc_top_test;
    localparam logic [15:0] RC  = pswc_pkg::RESET_CTRL_ADDR;
    localparam int          POR = int'(pswc_pkg::POR_DELAY_CYC);
    logic        clock, srst, sfr_wr, sfr_rd, tbl_rd, irq_wake, bor_rst, mclr_rst;
    logic [15:0] cfg_osc_in, cfg_wdt_in, cfg_borpor_in, cfg_seg_in;
    logic [15:0] sfr_addr, sfr_wdata, sfr_rdata, rd;
    logic [23:0] tbl_addr, tbl_rdata;
    logic        instr_watchdog_clear_instr, instr_power_save_instr, power_save_instr_sleep, prim_is_crystal, pll_en;
    logic        pll_lock, lp_kept_on, osc_running, failsafe_en, ref_stable, cpu_clk_en;
    logic        periph_clk_en, sys_osc_en, low_power_rc_oscillator_en, frc_force_en, clk_fail_trap;
    logic        irq_service, dev_reset, lvd_en;
    logic [1:0]  cur_osc_field, osc_restart_sel;
    logic [3:0]  lvd_level;
    logic [31:0] periph_off;
    int          mismatches, cmp_count, resets_seen;

    pswc_top #(.PWRT_CYCLES(16'd4)) dut (
        .clock, .srst, .cfg_osc_in, .cfg_wdt_in, .cfg_borpor_in, .cfg_seg_in,
        .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .tbl_addr, .tbl_rd,
        .tbl_rdata, .instr_watchdog_clear_instr, .instr_power_save_instr, .power_save_instr_sleep, .irq_wake, .bor_rst,
        .mclr_rst, .cur_osc_field, .prim_is_crystal, .pll_en, .pll_lock, .lp_kept_on,
        .osc_running, .failsafe_en, .ref_stable, .cpu_clk_en, .periph_clk_en,
        .sys_osc_en, .low_power_rc_oscillator_en, .osc_restart_sel, .frc_force_en, .clk_fail_trap,
        .irq_service, .dev_reset, .lvd_en, .lvd_level, .periph_off
    );
    pswc_core_model core (.clock, .instr_watchdog_clear_instr, .instr_power_save_instr, .power_save_instr_sleep);

    always #5 clock = ~clock;
    always @(posedge clock) if (dev_reset === 1'b1) resets_seen++;

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // each access leaves one idle edge so strobes never toggle twice in a step
    task automatic sfr_write(input logic [15:0] addr, input logic [15:0] data);
        sfr_addr = addr;
        sfr_wdata = data;
        sfr_wr = 1'b1;
        step(1);
        sfr_wr = 1'b0;
        step(1);
    endtask
    task automatic sfr_read(input logic [15:0] addr);
        sfr_addr = addr;
        sfr_rd = 1'b1;
        step(1);
        sfr_rd = 1'b0;
        rd = sfr_rdata;
        step(1);
    endtask
    task automatic wait_cpu(input int limit, output int n);
        n = 0;
        while (cpu_clk_en !== 1'b1 && n < limit) begin
            step(1);
            n++;
        end
    endtask
    task automatic reset_and_table();
        logic [23:0] addr [5];
        logic [15:0] word [5];
        addr = '{pswc_pkg::OSC_CFG_ADDR, pswc_pkg::WDT_CFG_ADDR,
                 pswc_pkg::BORPOR_CFG_ADDR, pswc_pkg::SEG_CFG_ADDR, 24'hf80006};
        word = '{cfg_osc_in, cfg_wdt_in, cfg_borpor_in, cfg_seg_in, 16'h0000};
        check({cpu_clk_en, periph_clk_en, sys_osc_en, low_power_rc_oscillator_en, lvd_en}, 5'h1c);
        check(periph_off, 32'h0);
        sfr_read(RC);
        check(rd, pswc_pkg::RC_POR_VALUE);
        foreach (addr[i]) begin
            tbl_addr = addr[i];
            tbl_rd = 1'b1;
            step(1);
            tbl_rd = 1'b0;
            check(tbl_rdata, {pswc_pkg::CFG_UPPER_FILL, word[i]});
            step(1);
        end
    endtask
    task automatic lvd_regs();
        sfr_write(RC, 16'h3a00);
        check({lvd_en, lvd_level}, 5'h1a);
        sfr_read(RC);
        check(rd, 16'h1a00);
        ref_stable = 1'b1;
        step(1);
        sfr_read(RC);
        check(rd[13], 1'b1);
        ref_stable = 1'b0;
        sfr_write(RC, 16'h0500);
        check({lvd_en, lvd_level}, 5'h05);
    endtask
    task automatic pmd_gating();
        sfr_addr = pswc_pkg::PMD1_ADDR;
        sfr_wdata = 16'h8001;
        sfr_wr = 1'b1;
        step(1);
        check(periph_off, 32'h0);
        sfr_addr = pswc_pkg::PMD2_ADDR;
        sfr_wdata = 16'h4002;
        step(1);
        sfr_wr = 1'b0;
        check(periph_off, 32'h0000_8001);
        step(1);
        check(periph_off, 32'h4002_8001);
        sfr_read(pswc_pkg::PMD2_ADDR);
        check(rd, 16'h4002);
        sfr_read(16'h0744);
        check(rd, 16'h0000);
        sfr_write(pswc_pkg::PMD1_ADDR, 16'h0000);
        sfr_write(pswc_pkg::PMD2_ADDR, 16'h0000);
        step(1);
        check(periph_off, 32'h0);
    endtask
    task automatic idle_wake();
        int n;
        sfr_write(RC, 16'h0000);
        core.exec_power_save_instr(1'b0);
        step(2);
        check({cpu_clk_en, periph_clk_en, sys_osc_en}, 3'b011);
        irq_wake = 1'b1;
        wait_cpu(3, n);
        irq_wake = 1'b0;
        check({n <= 2, irq_service}, 2'b11);
        sfr_read(RC);
        check(rd[2], 1'b1);
    endtask
    task automatic sleep_wake(input logic [1:0] src, input logic kept, input logic by_rst);
        int n;
        cur_osc_field = src;
        lp_kept_on = kept;
        sfr_write(RC, 16'h0000);
        core.exec_power_save_instr(1'b1);
        step(2);
        check({cpu_clk_en, periph_clk_en, sys_osc_en, low_power_rc_oscillator_en}, 4'h0);
        {mclr_rst, bor_rst} = {2{by_rst}};
        irq_wake = ~by_rst;
        step(1);
        {mclr_rst, bor_rst, irq_wake} = 3'b000;
        wait_cpu(1100, n);
        check(n >= POR - 3 && n <= POR + 2, 1'b1);
        check({irq_service, osc_restart_sel}, {~by_rst, src});
        sfr_read(RC);
        check({rd[7], rd[3], rd[1]}, {by_rst, 1'b1, by_rst});
    endtask
    task automatic crystal_fail();
        int n;
        cur_osc_field = pswc_pkg::OSC_SRC_PRIMARY;
        {prim_is_crystal, pll_en, failsafe_en} = 3'b111;
        core.exec_power_save_instr(1'b1);
        step(2);
        irq_wake = 1'b1;
        step(2);
        irq_wake = 1'b0;
        step(2500);
        check({cpu_clk_en, clk_fail_trap}, 2'b00);
        pll_lock = 1'b1;
        n = 0;
        while (clk_fail_trap !== 1'b1 && n < 10) begin
            step(1);
            n++;
        end
        check(clk_fail_trap, 1'b1);
        step(1);
        check({cpu_clk_en, frc_force_en, osc_restart_sel}, 4'hf);
        {prim_is_crystal, pll_en, pll_lock, failsafe_en} = 4'h0;
    endtask
    task automatic wdt_soft();
        int n;
        sfr_write(RC, 16'h0020);
        resets_seen = 0;
        step(20000);
        check(resets_seen, 0);
        core.exec_watchdog_clear_instr();
        n = 0;
        while (dev_reset !== 1'b1 && n < 26000) begin
            step(1);
            n++;
        end
        check(n >= 25500 && n <= 25700, 1'b1);
        sfr_read(RC);
        check(rd[4], 1'b1);
    endtask
    task automatic wdt_fuse_sleep();
        int n;
        cfg_wdt_in = 16'h8000;
        srst = 1'b1;
        step(3);
        srst = 1'b0;
        cur_osc_field = pswc_pkg::OSC_SRC_FAST_RC;
        core.exec_power_save_instr(1'b1);
        step(2);
        check(low_power_rc_oscillator_en, 1'b1);
        resets_seen = 0;
        wait_cpu(27500, n);
        check({n > 25000, cpu_clk_en, resets_seen == 0}, 3'b111);
        sfr_read(RC);
        check({rd[4], rd[3], rd[2]}, 3'b110);
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // full run is near 80k cycles, dominated by two watchdog time-outs
    initial begin
        #950_000;
        mismatches++;
        conclude();
    end
    initial begin
        clock = 1'b0;
        srst = 1'b1;
        {sfr_wr, sfr_rd, tbl_rd, irq_wake, bor_rst, mclr_rst, pll_en, pll_lock} = '0;
        {prim_is_crystal, lp_kept_on, osc_running, failsafe_en, ref_stable} = '0;
        {sfr_addr, sfr_wdata, tbl_addr} = '0;
        cur_osc_field = pswc_pkg::OSC_SRC_FAST_RC;
        cfg_osc_in = 16'h0147;
        cfg_wdt_in = 16'h0000;
        cfg_borpor_in = 16'h5a5a;
        cfg_seg_in = 16'h0003;
        mismatches = 0;
        cmp_count = 0;
        resets_seen = 0;
        step(3);
        srst = 1'b0;
        reset_and_table();
        lvd_regs();
        pmd_gating();
        idle_wake();
        sleep_wake(pswc_pkg::OSC_SRC_FAST_RC, 1'b0, 1'b0);
        sleep_wake(pswc_pkg::OSC_SRC_LOW_POWER_RC, 1'b0, 1'b0);
        sleep_wake(pswc_pkg::OSC_SRC_LP_CRYSTAL, 1'b1, 1'b0);
        sleep_wake(pswc_pkg::OSC_SRC_FAST_RC, 1'b0, 1'b1);
        crystal_fail();
        wdt_soft();
        wdt_fuse_sleep();
        conclude();
    end
endmodule // pswc_top_test
